/* include/adcof_pkg.sv */
package adcof_pkg;
   // ==========================================================
   // widths and timing
   localparam int WORD_W = 10;
   localparam int LVL_W = 12;
   localparam int LATENCY = 9;
   localparam int CNT_W = 8;
   localparam int BUF_DEPTH = 2;
   localparam int CLK_FREQ_KHZ = 40000;
   localparam int SRC_MIN_FREQ_KHZ = 20000;
   localparam int DUTY_PCT = 50;
   // longest input period the equalizer is specified for, in clock cycles (rounded down)
   localparam int SRC_MAX_PERIOD_CYC = CLK_FREQ_KHZ / SRC_MIN_FREQ_KHZ;
   localparam logic [CNT_W-1:0] PERIOD_MAX = 8'hff;
   localparam logic [CNT_W-1:0] HALF_MIN = 8'h01;

   // ==========================================================
   // full-scale levels of the corrected quantizer result
   localparam logic signed [LVL_W-1:0] POS_FULL = 12'sh1ff;
   localparam logic signed [LVL_W-1:0] NEG_FULL = 12'she00;
   localparam logic [WORD_W-1:0] WORD_RESET = 10'h000;
   localparam logic [WORD_W-1:0] WORD_ONES = 10'h3ff;

   // ==========================================================
   // shared types
   typedef struct packed
   {
      logic flag;
      logic [WORD_W-1:0] word;
   } adcof_sample_s;

   typedef struct packed
   {
      adcof_sample_s [BUF_DEPTH-1:0] mem;
      logic wr_ptr;
      logic rd_ptr;
      logic [1:0] count;
   } adcof_buf_state_s;

   localparam logic [1:0] BUF_FULL_COUNT = 2'h2;
   localparam adcof_buf_state_s BUF_STATE_RESET = '{default: '0};

   typedef struct packed
   {
      logic prev_true;
      logic div_phase;
      logic [CNT_W-1:0] period_cnt;
      logic [CNT_W-1:0] half_period;
      logic [LATENCY-1:0] pipe_valid;
      adcof_sample_s [LATENCY-1:0] pipe;
      logic [WORD_W-1:0] word_true;
      logic [WORD_W-1:0] word_comp;
      logic flag_true;
      logic flag_comp;
      logic fwd_start;
      logic fwd_true;
      logic fwd_comp;
      logic [CNT_W-1:0] fwd_cnt;
      logic overrun;
   } adcof_fmt_state_s;

   localparam adcof_fmt_state_s FMT_STATE_RESET = '{
      period_cnt: HALF_MIN,
      half_period: HALF_MIN,
      word_comp: WORD_ONES,
      flag_comp: 1'b1,
      fwd_comp: 1'b1,
      default: '0
   };
endpackage

/* include/adcof_buf_if.sv */
interface adcof_buf_if;
   import adcof_pkg::*;
   adcof_sample_s in_data;
   logic in_valid;
   logic in_ready;
   adcof_sample_s out_data;
   logic out_valid;
   logic out_ready;

   modport fifo
   (
      input in_data,
      input in_valid,
      output in_ready,
      output out_data,
      output out_valid,
      input out_ready
   );

   modport user
   (
      output in_data,
      output in_valid,
      input in_ready,
      input out_data,
      input out_valid,
      output out_ready
   );
endinterface

/* src/adcof_buffer.sv */
module adcof_buffer
(
   input wire logic clock,
   input wire logic clock_en,
   input wire logic reset_n,
   adcof_buf_if.fifo bus
);
   import adcof_pkg::*;

   adcof_buf_state_s st;
   adcof_buf_state_s next_st;
   logic push;
   logic pop;

   // ==========================================================
   // handshake
   assign bus.in_ready = (st.count != BUF_FULL_COUNT);
   assign bus.out_valid = (st.count != 2'h0);
   assign bus.out_data = st.mem[st.rd_ptr];
   assign push = bus.in_valid && bus.in_ready;
   assign pop = bus.out_valid && bus.out_ready;

   // ==========================================================
   // storage
   always_comb
   begin
      next_st = st;
      if (push)
      begin
         next_st.mem[st.wr_ptr] = bus.in_data;
         next_st.wr_ptr = ~st.wr_ptr;
      end
      if (pop)
      begin
         next_st.rd_ptr = ~st.rd_ptr;
      end
      // full refuses a push, so a simultaneous push and pop keeps the count
      unique case ({push, pop})
         2'b10: next_st.count = st.count + 2'h1;
         2'b01: next_st.count = st.count - 2'h1;
         2'b00, 2'b11: next_st.count = st.count;
      endcase
   end

   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
      begin
         st <= BUF_STATE_RESET;
      end
      else if (clock_en)
      begin
         st <= next_st;
      end
   end
endmodule // adcof_buffer

/* src/adcof_formatter.sv */
// Notes on behaviour
// (RULE_01) a sample is taken when the true clock rises, the complement falling
// (RULE_02) each word leaves the pipeline nine conversion clocks after its sample
// (RULE_03) word is valid at the next forwarded clock rising edge; receiver captures there
// (RULE_04) receiver may latch data and synchronise itself with the forwarded clock
// (RULE_05) format low gives two's complement, high gives offset binary
// (RULE_06) an open format input pulls low, giving two's complement
// (RULE_07) each result is delivered as one corrected 10-bit parallel word
// (RULE_08) offset binary: all ones, all zeros, midscale 10 0000 0000
// (RULE_09) two's complement: 01 1111 1111, 10 0000 0000, midscale zero
// (RULE_10) beyond full scale the word clamps to full-scale code and flag sets
// (RULE_11) flag true leg high, complement low when out of range, opposite otherwise
// (RULE_12) exactly full scale is in range
// (RULE_13) halve control low enables divide-by-2, output at half rate
// (RULE_14) halve control high bypasses divider, output at full rate
// (RULE_15) an open halve control pulls low, selecting divide-by-2
// (RULE_16) a 50% duty internal clock is always regenerated; source above 20MHz
// (RULE_17) every complementary leg is the inverse of its true leg
// (RULE_18) the range flag travels the same pipeline as its word
module adcof_formatter
(
   input wire logic clock,
   input wire logic clock_en,
   input wire logic reset_n,
   input wire logic sample_clock_true,
   input wire logic sample_clock_comp,
   input wire logic signed [adcof_pkg::LVL_W-1:0] sample_level,
   input wire logic format_select,
   input wire logic clock_halve_ctrl,
   input wire logic rx_ready,
   output logic [adcof_pkg::WORD_W-1:0] sample_word_true,
   output logic [adcof_pkg::WORD_W-1:0] sample_word_comp,
   output logic range_flag_true,
   output logic range_flag_comp,
   output logic fwd_clock_true,
   output logic fwd_clock_comp,
   output logic overrun
);
   import adcof_pkg::*;

   adcof_fmt_state_s st;
   adcof_fmt_state_s next_st;
   adcof_buf_if buf_bus();

   logic raw_rise;
   logic conv_edge;
   logic out_of_range;
   logic [WORD_W-1:0] twos_word;
   logic [WORD_W-1:0] coded_word;
   logic stall;
   logic pop;

   // ==========================================================
   // regenerated half period, never below one cycle
   function automatic logic [CNT_W-1:0] half_of(input logic [CNT_W-1:0] period);
      logic [15:0] scaled;
      scaled = 16'((int'(period) * DUTY_PCT) / 100);
      if (scaled[15:CNT_W] != '0)
      begin
         return PERIOD_MAX;
      end
      else if (scaled[CNT_W-1:0] < HALF_MIN)
      begin
         return HALF_MIN;
      end
      return scaled[CNT_W-1:0];
   endfunction

   // ==========================================================
   // sample edge and divider
   // both legs are checked so a glitch on one leg alone takes no sample
   assign raw_rise = sample_clock_true && !sample_clock_comp && !st.prev_true; // RULE_01
   // pads pull the halve control low when open
   assign conv_edge = raw_rise && (clock_halve_ctrl || st.div_phase); // RULE_13 RULE_14 RULE_15

   // ==========================================================
   // range check, clamp and coding
   assign out_of_range = (sample_level > POS_FULL) || (sample_level < NEG_FULL); // RULE_10 RULE_12

   always_comb
   begin
      if (sample_level > POS_FULL)
      begin
         twos_word = POS_FULL[WORD_W-1:0]; // RULE_10
      end
      else if (sample_level < NEG_FULL)
      begin
         twos_word = NEG_FULL[WORD_W-1:0]; // RULE_10
      end
      else
      begin
         twos_word = sample_level[WORD_W-1:0]; // RULE_07 RULE_09
      end
   end

   // offset binary is two's complement with the sign bit inverted; an open select reads low
   assign coded_word = format_select ? {~twos_word[WORD_W-1], twos_word[WORD_W-2:0]} : twos_word; // RULE_05 RULE_06 RULE_08

   // ==========================================================
   // output buffer
   adcof_buffer u_buffer
   (
      .clock(clock),
      .clock_en(clock_en),
      .reset_n(reset_n),
      .bus(buf_bus.fifo)
   );

   assign buf_bus.in_data = st.pipe[LATENCY-1];
   assign buf_bus.in_valid = conv_edge && st.pipe_valid[LATENCY-1]; // RULE_02
   // a word that cannot enter the buffer holds the pipeline; the new sample is lost
   assign stall = buf_bus.in_valid && !buf_bus.in_ready;
   // no new word while the forwarded clock is high or about to rise
   assign pop = buf_bus.out_valid && rx_ready && !st.fwd_true && !st.fwd_start;
   assign buf_bus.out_ready = pop;

   // ==========================================================
   // next state
   always_comb
   begin
      next_st = st;
      next_st.prev_true = sample_clock_true;
      next_st.overrun = stall;

      if (raw_rise && !clock_halve_ctrl)
      begin
         next_st.div_phase = ~st.div_phase; // RULE_13
      end
      else if (clock_halve_ctrl)
      begin
         next_st.div_phase = 1'b0;
      end

      // duty-cycle equalizer: measure conversion period, keep half of it
      // limitation: periods above 255 cycles saturate
      if (conv_edge)
      begin
         next_st.period_cnt = HALF_MIN;
         next_st.half_period = half_of(st.period_cnt); // RULE_16
      end
      else if (st.period_cnt != PERIOD_MAX)
      begin
         next_st.period_cnt = st.period_cnt + HALF_MIN;
      end

      // conversion pipeline, flag alongside word
      if (conv_edge && !stall)
      begin
         for (int i = LATENCY - 1; i > 0; i--)
         begin
            next_st.pipe[i] = st.pipe[i-1]; // RULE_02 RULE_18
            next_st.pipe_valid[i] = st.pipe_valid[i-1];
         end
         next_st.pipe[0].word = coded_word; // RULE_07
         next_st.pipe[0].flag = out_of_range; // RULE_18
         next_st.pipe_valid[0] = 1'b1;
      end

      // output word, then forwarded clock rises one cycle later
      if (pop)
      begin
         next_st.word_true = buf_bus.out_data.word;
         next_st.word_comp = ~buf_bus.out_data.word; // RULE_17
         next_st.flag_true = buf_bus.out_data.flag; // RULE_11
         next_st.flag_comp = ~buf_bus.out_data.flag; // RULE_11 RULE_17
         next_st.fwd_start = 1'b1;
      end

      if (st.fwd_start)
      begin
         next_st.fwd_start = 1'b0;
         next_st.fwd_true = 1'b1; // RULE_03
         next_st.fwd_comp = 1'b0; // RULE_17
         next_st.fwd_cnt = st.half_period; // RULE_16
      end
      else if (st.fwd_true)
      begin
         if (st.fwd_cnt <= HALF_MIN)
         begin
            next_st.fwd_true = 1'b0;
            next_st.fwd_comp = 1'b1; // RULE_17
            next_st.fwd_cnt = '0;
         end
         else
         begin
            next_st.fwd_cnt = st.fwd_cnt - HALF_MIN;
         end
      end
   end

   // ==========================================================
   // state register
   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
      begin
         st <= FMT_STATE_RESET;
      end
      else if (clock_en)
      begin
         st <= next_st;
      end
   end

   // ==========================================================
   // outputs, all straight from the state register
   assign sample_word_true = st.word_true;
   assign sample_word_comp = st.word_comp;
   assign range_flag_true = st.flag_true;
   assign range_flag_comp = st.flag_comp;
   assign fwd_clock_true = st.fwd_true;
   assign fwd_clock_comp = st.fwd_comp;
   assign overrun = st.overrun;
endmodule // adcof_formatter

/* tb/adcof_chk.sv */
module adcof_chk
(
   input wire logic clock,
   input wire logic clock_en,
   input wire logic reset_n,
   input wire logic rx_ready,
   input wire logic [adcof_pkg::WORD_W-1:0] sample_word_true,
   input wire logic [adcof_pkg::WORD_W-1:0] sample_word_comp,
   input wire logic range_flag_true,
   input wire logic range_flag_comp,
   input wire logic fwd_clock_true,
   input wire logic fwd_clock_comp,
   input wire logic overrun
);
   timeunit 1ns;
   timeprecision 100ps;
   // ==========
   // output legs and framing
   default clocking @(posedge clock); endclocking
   default disable iff (!reset_n);
   a_word_legs_inverse: assert property (sample_word_comp == ~sample_word_true)
      else $error("word legs not inverse");
   a_flag_legs_inverse: assert property (range_flag_comp == !range_flag_true)
      else $error("flag legs not inverse");
   a_fwd_legs_inverse: assert property (fwd_clock_comp == !fwd_clock_true)
      else $error("forwarded clock legs not inverse");
   a_word_held_fwd: assert property (fwd_clock_true |-> $stable(sample_word_true) && $stable(range_flag_true))
      else $error("word moved while forwarded clock high");
   a_flag_clamps_word: assert property (range_flag_true |-> sample_word_true inside {10'h1ff, 10'h3ff, 10'h200, 10'h000})
      else $error("flagged word not full scale");
   a_fwd_low_gap: assert property ($fell(fwd_clock_true) |=> !fwd_clock_true)
      else $error("forwarded clock low for one cycle only");
   a_stall_holds_word: assert property (!rx_ready [*3] |-> $stable(sample_word_true))
      else $error("word changed during stall");
   a_enable_freezes: assert property (!clock_en |=> $stable(sample_word_true) && $stable(fwd_clock_true))
      else $error("outputs moved while disabled");
   a_overrun_single: assert property (overrun |=> !overrun)
      else $error("overrun longer than one cycle");
   c_fwd_rise: cover property ($rose(fwd_clock_true));
   c_flagged: cover property (range_flag_true && $rose(fwd_clock_true));
   c_overrun: cover property (overrun);
endmodule // adcof_chk

/* tb/adcof_rx_model.sv */
module adcof_rx_model
(
   input wire logic clock,
   input wire logic stall,
   input wire logic [adcof_pkg::WORD_W-1:0] sample_word_true,
   input wire logic range_flag_true,
   input wire logic fwd_clock_true,
   output logic rx_ready
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [adcof_pkg::WORD_W:0] got[$];
   initial rx_ready = 1'b1;
   // ==========
   // receiver
   always @(posedge clock)
   begin
      rx_ready <= !stall;
   end
   // word and flag latched together on the forwarded edge
   always @(posedge fwd_clock_true)
   begin
      got.push_back({range_flag_true, sample_word_true});
   end
endmodule // adcof_rx_model

/* tb/adcof_formatter_tb_top.sv */
module adcof_formatter_tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   import adcof_pkg::*;
   typedef struct packed
   {
      logic [LVL_W-1:0] lvl;
      logic fmt;
      logic [WORD_W:0] exp;
   } adcof_row_s;
   // ==========
   // coding table: level, format, {flag, word}
   localparam adcof_row_s ROWS[14] = '{
      '{12'h1ff, 1'b0, 11'h1ff}, '{12'h1ff, 1'b1, 11'h3ff}, '{12'he00, 1'b0, 11'h200},
      '{12'he00, 1'b1, 11'h000}, '{12'h000, 1'b0, 11'h000}, '{12'h000, 1'b1, 11'h200},
      '{12'hfff, 1'b0, 11'h3ff}, '{12'hfff, 1'b1, 11'h1ff}, '{12'h200, 1'b0, 11'h5ff},
      '{12'h258, 1'b1, 11'h7ff}, '{12'hdff, 1'b0, 11'h600}, '{12'h800, 1'b1, 11'h400},
      '{12'h7ff, 1'b0, 11'h5ff}, '{12'h005, 1'b1, 11'h205}};
   logic clock = 1'b0;
   logic reset_n = 1'b0;
   logic clock_en = 1'b1;
   logic sample_clock_true = 1'b0;
   logic sample_clock_comp = 1'b1;
   logic signed [LVL_W-1:0] sample_level = '0;
   logic format_select = 1'b0;
   logic clock_halve_ctrl = 1'b1;
   logic stall = 1'b0;
   logic ovr_seen = 1'b0;
   logic rx_ready;
   logic [WORD_W-1:0] sample_word_true;
   logic [WORD_W-1:0] sample_word_comp;
   logic range_flag_true;
   logic range_flag_comp;
   logic fwd_clock_true;
   logic fwd_clock_comp;
   logic overrun;
   int err_count = 0;
   int total_checks = 0;
   int cycles = 0;
   int fwd_hi = 0;
   int fwd_len = 0;

   adcof_formatter uut (.clock, .clock_en, .reset_n, .sample_clock_true, .sample_clock_comp, .sample_level,
      .format_select, .clock_halve_ctrl, .rx_ready, .sample_word_true, .sample_word_comp, .range_flag_true,
      .range_flag_comp, .fwd_clock_true, .fwd_clock_comp, .overrun);
   adcof_rx_model rx (.clock, .stall, .sample_word_true, .range_flag_true, .fwd_clock_true, .rx_ready);

   always #12.5 clock = ~clock;
   always @(posedge clock)
   begin
      if (overrun === 1'b1)
         ovr_seen <= 1'b1;
      // length of the latest forwarded clock high phase, in clocks
      if (fwd_clock_true === 1'b1)
         fwd_hi++;
      else if (fwd_hi != 0)
      begin
         fwd_len = fwd_hi;
         fwd_hi = 0;
      end
      cycles++;
      // whole run needs well under a thousand cycles
      if (cycles == 3000)
      begin
         err_count++;
         print_verdict();
      end
   end

   task automatic check(input logic [WORD_W:0] seen, input logic [WORD_W:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         err_count++;
         $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic print_verdict();
      $display("checks=%0d errors=%0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   task automatic do_reset();
      reset_n = 1'b0;
      repeat (6) @(negedge clock);
      check({range_flag_comp, sample_word_comp}, 11'h7ff);
      check({range_flag_true, sample_word_true}, 11'h000);
      reset_n = 1'b1;
   endtask

   // one source period of six clocks, level and format set as the true leg rises
   task automatic sample(input logic [LVL_W-1:0] lv, input logic f);
      @(negedge clock);
      sample_level = lv;
      format_select = f;
      sample_clock_true = 1'b1;
      sample_clock_comp = 1'b0;
      repeat (3) @(negedge clock);
      sample_clock_true = 1'b0;
      sample_clock_comp = 1'b1;
      repeat (2) @(negedge clock);
   endtask

   initial
   begin
      do_reset();
      foreach (ROWS[i])
         sample(ROWS[i].lvl, ROWS[i].fmt);
      repeat (9) sample(12'h000, 1'b0);
      repeat (20) @(negedge clock);
      check(11'(rx.got.size()), 11'h00e);
      foreach (ROWS[i])
         check(rx.got[i], ROWS[i].exp);
      // six-clock source period, so half of it high
      check(11'(fwd_len), 11'h003);
      // stall the receiver until the two-entry buffer refuses
      stall = 1'b1;
      clock_en = 1'b0;
      repeat (3) @(negedge clock);
      clock_en = 1'b1;
      repeat (4) sample(12'h000, 1'b0);
      check(11'(ovr_seen), 11'h001);
      check(11'(rx.got.size()), 11'h00e);
      stall = 1'b0;
      repeat (20) @(negedge clock);
      check(11'(rx.got.size()), 11'h010);
      // divide-by-2: only every second source edge converts, the first after reset skipped
      clock_halve_ctrl = 1'b0;
      do_reset();
      rx.got.delete();
      for (int i = 0; i < 24; i++)
         sample(12'(i), 1'b0);
      repeat (30) @(negedge clock);
      check(11'(rx.got.size()), 11'h003);
      for (int j = 0; j < 3; j++)
         check(rx.got[j], 11'(2 * j + 1));
      // conversion period doubles to twelve clocks
      check(11'(fwd_len), 11'h006);
      print_verdict();
   end
endmodule // adcof_formatter_tb_top

bind adcof_formatter adcof_chk chk (.clock, .clock_en, .reset_n, .rx_ready, .sample_word_true, .sample_word_comp,
   .range_flag_true, .range_flag_comp, .fwd_clock_true, .fwd_clock_comp, .overrun);
